// ---- design/spdp_regs.svh ----
// Purpose: constants of the serial store with lower-half write lock
// Assumes: clk_sys at 40 MHz
// Notes: widths of each constant match what it meets
`ifndef SPDP_REGS_SVH
`define SPDP_REGS_SVH
`define SPDP_CLK_NS 25
`define SPDP_FILT_NS 50
`define SPDP_FILT_CYC ((`SPDP_FILT_NS + `SPDP_CLK_NS - 1) / `SPDP_CLK_NS)
`define SPDP_WR_CYCLE_US 5000
`define SPDP_WR_CYC (`SPDP_WR_CYCLE_US * 1000 / `SPDP_CLK_NS)
`define SPDP_FILT_RST 2'h1
`define SPDP_BITS 4'h8
`define SPDP_IDX_MAX 2'h3
`define SPDP_CODE_MEM 4'hA
`define SPDP_CODE_PROT 4'h6
`define SPDP_CODE_TS 4'h3
`define SPDP_REG_CAP 8'h00
`define SPDP_REG_CFG 8'h01
`define SPDP_REG_UPPER 8'h02
`define SPDP_REG_LOWER 8'h03
`define SPDP_REG_CRIT 8'h04
`define SPDP_REG_TEMP 8'h05
`define SPDP_REG_MAKER 8'h06
`define SPDP_REG_PART 8'h07
`define SPDP_REG_TMO 8'h22
`define SPDP_PTR_RST 8'h00
`define SPDP_CAP_RST 16'h0017
`define SPDP_RW_RST 16'h0000
// identity values are arbitrary
`define SPDP_MAKER_ID 16'h5A5A
`define SPDP_PART_ID 16'h0C01
`define SPDP_NV_NONE 2'h0
`define SPDP_NV_REV 2'h1
`define SPDP_NV_PERM 2'h2
`endif

// ---- design/spdp_pkg.sv ----
// Purpose: types of the serial store with lower-half write lock
// Assumes: nothing
// Notes: all enums one-hot
package spdp_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_ADDR = 7'h02, ST_ADDR_ACK = 7'h04, ST_RX = 7'h08,
        ST_RX_ACK = 7'h10, ST_TX = 7'h20, ST_TX_ACK = 7'h40
    } spdp_state_t;
    typedef enum logic [2:0] {PROT_NONE = 3'h1, PROT_REV = 3'h2, PROT_PERM = 3'h4} spdp_prot_t;
    typedef enum logic [3:0] {TGT_NONE = 4'h1, TGT_MEM = 4'h2, TGT_PROT = 4'h4, TGT_TS = 4'h8} spdp_tgt_t;
    typedef enum logic [3:0] {OP_NONE = 4'h1, OP_REV = 4'h2, OP_CLR = 4'h4, OP_PERM = 4'h8} spdp_op_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } spdp_bus_t;
endpackage

// ---- design/spdp_access.sv ----
// Purpose: serial slave for 256-byte store, lock logic and sensor registers
// Assumes: scl_in/sda_in synchronous to clk_sys; lock state kept outside
// Notes: memory and lock are not cleared by rst_n
`timescale 1ns/1ps
`include "spdp_regs.svh"
module spdp_access
    import spdp_pkg::*;
#(
    parameter int unsigned WR_CYC = `SPDP_WR_CYC,
    parameter logic [15:0] MAKER_ID = `SPDP_MAKER_ID,
    parameter logic [15:0] PART_ID = `SPDP_PART_ID
)
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] addr_sel,
    input wire logic hv_detect_in,
    input wire logic [1:0] nv_prot_init,
    input wire logic [15:0] temp_value_in,
    output logic [1:0] prot_state_o,
    output logic wr_busy_o
);
    localparam logic [1:0] FILT_RST = `SPDP_FILT_RST;

    spdp_state_t state_r;
    spdp_prot_t prot_r;
    spdp_tgt_t tgt_r, tgt_d;
    spdp_op_t op_r, op_d, pend_op_r, wr_op_r;
    spdp_bus_t filt, prev_r;
    logic filt_a [2];
    logic [1:0] raw_v;
    logic hv_s1_r, hv_s2_r, por_hold_r;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r, tx_sh_r, tx_byte, addr_cnt_r, ptr_r, hi_r;
    logic [1:0] byte_idx_r, prot_o_r;
    logic ack_en_r, rw_r, mack_r, addr_ack_d, data_ack_d;
    logic addr_done, data_done, tx_load, commit_ok;
    logic pend_mem_r, wr_mem_r, wr_busy_r, wr_end;
    logic [31:0] wr_tmr_r;
    logic [7:0] buf_a [16];
    logic [15:0] buf_v_r;
    logic [7:0] mem_a [256];
    logic [15:0] cfg_r, upper_r, lower_r, crit_r, tmo_r, ts_rd;
    logic sda_oe_r, sda_out_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ****************
    // input filter
    // ****************
    assign raw_v = {scl_in, sda_in};
    for (genvar g = 0; g < 2; g++)
    begin : g_filt
        logic [1:0] cnt_r;
        always_ff @(posedge clk_sys)
        begin
            if (!rst_n)
            begin
                filt_a[g] <= FILT_RST[g];
                cnt_r <= 2'h0;
            end
            else if (raw_v[g] == filt_a[g])
                cnt_r <= 2'h0;
            else if (cnt_r == 2'(`SPDP_FILT_CYC - 1))
            begin
                filt_a[g] <= raw_v[g];
                cnt_r <= 2'h0;
            end
            else
                cnt_r <= cnt_r + 2'h1;
        end
    end
    assign filt = spdp_bus_t'({filt_a[1], filt_a[0]});

    a_glitch_reject: assert property ((!filt_a[1] && scl_in && !$past(scl_in)) ##1 !scl_in |-> ##1 !filt_a[1])
        else $error("short clock pulse passed filter");

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            prev_r <= spdp_bus_t'(FILT_RST);
            hv_s1_r <= 1'b0;
            hv_s2_r <= 1'b0;
            por_hold_r <= 1'b1;
        end
        else
        begin
            prev_r <= filt;
            hv_s1_r <= hv_detect_in;
            hv_s2_r <= hv_s1_r;
            if (filt.scl)
                por_hold_r <= 1'b0;
        end
    end

    assign scl_rise = filt.scl & ~prev_r.scl;
    assign scl_fall = ~filt.scl & prev_r.scl;
    assign bus_start = filt.scl & prev_r.scl & prev_r.sda & ~filt.sda;
    assign bus_stop = filt.scl & prev_r.scl & ~prev_r.sda & filt.sda;
    assign addr_done = scl_fall && state_r == ST_ADDR && bitcnt_r == `SPDP_BITS;
    assign data_done = scl_fall && state_r == ST_RX && bitcnt_r == `SPDP_BITS;
    assign tx_load = scl_fall && ((state_r == ST_ADDR_ACK && ack_en_r && rw_r && tgt_r != TGT_PROT)
        || (state_r == ST_TX_ACK && mack_r));
    assign wr_end = wr_busy_r && wr_tmr_r == 32'h1;
    assign commit_ok = !(prot_r == PROT_NONE && op_r == OP_CLR);

    // ****************
    // decode and answers
    // ****************
    always_comb
    begin
        op_d = OP_NONE;
        tgt_d = TGT_NONE;
        addr_ack_d = 1'b0;
        if (shift_r[7:4] == `SPDP_CODE_MEM && shift_r[3:1] == addr_sel)
        begin
            tgt_d = TGT_MEM;
            addr_ack_d = !wr_busy_r;
        end
        else if (shift_r[7:4] == `SPDP_CODE_TS && shift_r[3:1] == addr_sel)
        begin
            tgt_d = TGT_TS;
            addr_ack_d = 1'b1;
        end
        else if (shift_r[7:4] == `SPDP_CODE_PROT)
        begin
            // selector levels pick the command; the rw bit only picks query
            if (hv_s2_r && shift_r[3:2] == 2'h0)
                op_d = OP_REV;
            else if (hv_s2_r && shift_r[3:2] == 2'h1)
                op_d = OP_CLR;
            else if (!hv_s2_r && shift_r[3:1] == addr_sel)
                op_d = OP_PERM;
            if (op_d != OP_NONE)
            begin
                tgt_d = TGT_PROT;
                // same answer for command and query byte
                addr_ack_d = !wr_busy_r && prot_r != PROT_PERM && !(prot_r == PROT_REV && op_d == OP_REV);
            end
        end
    end

    always_comb
    begin
        case (tgt_r)
            TGT_MEM: data_ack_d = byte_idx_r == 2'h0 || prot_r == PROT_NONE || addr_cnt_r[7];
            TGT_PROT: data_ack_d = ack_en_r;
            TGT_TS: data_ack_d = 1'b1;
            default: data_ack_d = 1'b0;
        endcase
    end

    always_comb
    begin
        case (ptr_r)
            `SPDP_REG_CAP: ts_rd = `SPDP_CAP_RST;
            `SPDP_REG_CFG: ts_rd = cfg_r;
            `SPDP_REG_UPPER: ts_rd = upper_r;
            `SPDP_REG_LOWER: ts_rd = lower_r;
            `SPDP_REG_CRIT: ts_rd = crit_r;
            `SPDP_REG_TEMP: ts_rd = temp_value_in;
            `SPDP_REG_MAKER: ts_rd = MAKER_ID;
            `SPDP_REG_PART: ts_rd = PART_ID;
            `SPDP_REG_TMO: ts_rd = tmo_r;
            default: ts_rd = 16'h0000;
        endcase
    end

    always_comb
    begin
        case (tgt_r)
            TGT_MEM: tx_byte = mem_a[addr_cnt_r];
            TGT_TS: tx_byte = byte_idx_r[0] ? ts_rd[7:0] : ts_rd[15:8];
            default: tx_byte = 8'hFF;
        endcase
    end

    // ****************
    // bit engine
    // ****************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || por_hold_r)
        begin
            state_r <= ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_sh_r <= 8'hFF;
            mack_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end
        else if (bus_start)
        begin
            state_r <= ST_ADDR;
            bitcnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
        end
        else if (bus_stop)
        begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_ADDR, ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_r <= {shift_r[6:0], filt.sda};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                    else if (addr_done)
                    begin
                        state_r <= ST_ADDR_ACK;
                        sda_oe_r <= addr_ack_d;
                    end
                    else if (data_done)
                    begin
                        state_r <= ST_RX_ACK;
                        sda_oe_r <= data_ack_d;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (tx_load)
                    begin
                        state_r <= ST_TX;
                        tx_sh_r <= tx_byte;
                        sda_oe_r <= !tx_byte[7];
                        bitcnt_r <= 4'h0;
                    end
                    else if (scl_fall)
                    begin
                        // a query is done after its command byte
                        state_r <= (ack_en_r && !rw_r) ? ST_RX : ST_IDLE;
                        sda_oe_r <= 1'b0;
                        bitcnt_r <= 4'h0;
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_r <= ST_RX;
                        sda_oe_r <= 1'b0;
                        bitcnt_r <= 4'h0;
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                        bitcnt_r <= bitcnt_r + 4'h1;
                    else if (scl_fall && bitcnt_r == `SPDP_BITS)
                    begin
                        state_r <= ST_TX_ACK;
                        sda_oe_r <= 1'b0;
                    end
                    else if (scl_fall)
                    begin
                        tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                        sda_oe_r <= !tx_sh_r[6];
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                        mack_r <= !filt.sda;
                    else if (tx_load)
                    begin
                        state_r <= ST_TX;
                        tx_sh_r <= tx_byte;
                        sda_oe_r <= !tx_byte[7];
                        bitcnt_r <= 4'h0;
                    end
                    else if (scl_fall)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    a_por_hold: assert property (por_hold_r |-> state_r == ST_IDLE && !sda_oe_r)
        else $error("bus active while clock line held low after reset");
    a_query_cmd_only: assert property (scl_fall && state_r == ST_ADDR_ACK && tgt_r == TGT_PROT && rw_r
        |=> state_r == ST_IDLE && !sda_oe_r)
        else $error("query went past its command byte");
    a_perm_prot_nack: assert property (state_r == ST_ADDR_ACK && tgt_r == TGT_PROT && prot_r == PROT_PERM
        |-> !sda_oe_r)
        else $error("lock command acked after permanent lock");
    a_busy_nack: assert property (state_r == ST_ADDR_ACK && tgt_r == TGT_MEM && wr_busy_r |-> !sda_oe_r)
        else $error("memory address acked during write cycle");
    a_lower_nack: assert property (state_r == ST_RX_ACK && tgt_r == TGT_MEM && byte_idx_r >= 2'h2
        && prot_r != PROT_NONE && !addr_cnt_r[7] |-> !sda_oe_r)
        else $error("locked lower-half data byte acked");

    // ****************
    // transaction state
    // ****************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tgt_r <= TGT_NONE;
            op_r <= OP_NONE;
            ack_en_r <= 1'b0;
            rw_r <= 1'b0;
            byte_idx_r <= 2'h0;
            addr_cnt_r <= 8'h00;
            ptr_r <= `SPDP_PTR_RST;
            hi_r <= 8'h00;
            buf_v_r <= 16'h0000;
            pend_mem_r <= 1'b0;
            pend_op_r <= OP_NONE;
        end
        else if (bus_start || bus_stop)
        begin
            // stop hands the pending write to the write timer; a restart drops it
            pend_mem_r <= 1'b0;
            pend_op_r <= OP_NONE;
        end
        else if (addr_done)
        begin
            tgt_r <= tgt_d;
            op_r <= op_d;
            ack_en_r <= addr_ack_d;
            rw_r <= shift_r[0];
            byte_idx_r <= 2'h0;
            if (tgt_d == TGT_MEM && !shift_r[0] && addr_ack_d)
                buf_v_r <= 16'h0000;
        end
        else if (data_done)
        begin
            if (byte_idx_r != `SPDP_IDX_MAX)
                byte_idx_r <= byte_idx_r + 2'h1;
            case (tgt_r)
                TGT_MEM:
                begin
                    if (byte_idx_r == 2'h0)
                        addr_cnt_r <= shift_r;
                    else if (data_ack_d)
                    begin
                        buf_a[addr_cnt_r[3:0]] <= shift_r;
                        buf_v_r[addr_cnt_r[3:0]] <= 1'b1;
                        addr_cnt_r[3:0] <= addr_cnt_r[3:0] + 4'h1;
                        pend_mem_r <= 1'b1;
                    end
                end
                TGT_PROT:
                begin
                    // only the frame length counts, never the byte values
                    if (byte_idx_r == 2'h1 && ack_en_r && commit_ok)
                        pend_op_r <= op_r;
                end
                TGT_TS:
                begin
                    if (byte_idx_r == 2'h0)
                        ptr_r <= shift_r;
                    else if (byte_idx_r == 2'h1)
                        hi_r <= shift_r;
                end
                default: ;
            endcase
        end
        else if (tx_load)
        begin
            if (tgt_r == TGT_MEM)
                addr_cnt_r <= addr_cnt_r + 8'h01;
            byte_idx_r <= {1'b0, ~byte_idx_r[0]};
        end
    end

    a_read_wrap: assert property (tx_load && tgt_r == TGT_MEM && addr_cnt_r == 8'hFF |=> addr_cnt_r == 8'h00)
        else $error("read counter did not wrap to zero");
    a_page_wrap: assert property (data_done && tgt_r == TGT_MEM && data_ack_d && byte_idx_r != 2'h0
        |=> $stable(addr_cnt_r[7:4]) && addr_cnt_r[3:0] == $past(addr_cnt_r[3:0]) + 4'h1)
        else $error("page write left its page");

    // ****************
    // sensor registers
    // ****************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cfg_r <= `SPDP_RW_RST;
            upper_r <= `SPDP_RW_RST;
            lower_r <= `SPDP_RW_RST;
            crit_r <= `SPDP_RW_RST;
            tmo_r <= `SPDP_RW_RST;
        end
        else if (data_done && tgt_r == TGT_TS && byte_idx_r == 2'h2)
        begin
            case (ptr_r)
                `SPDP_REG_CFG: cfg_r <= {hi_r, shift_r};
                `SPDP_REG_UPPER: upper_r <= {hi_r, shift_r};
                `SPDP_REG_LOWER: lower_r <= {hi_r, shift_r};
                `SPDP_REG_CRIT: crit_r <= {hi_r, shift_r};
                `SPDP_REG_TMO: tmo_r <= {hi_r, shift_r};
                default: ; // read-only and reserved left unchanged
            endcase
        end
    end

    // ****************
    // write cycle and lock state
    // ****************
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_busy_r <= 1'b0;
            wr_tmr_r <= 32'h0;
            wr_mem_r <= 1'b0;
            wr_op_r <= OP_NONE;
            case (nv_prot_init) // lock survives reset through the outside store
                `SPDP_NV_REV: prot_r <= PROT_REV;
                `SPDP_NV_PERM: prot_r <= PROT_PERM;
                default: prot_r <= PROT_NONE;
            endcase
        end
        else if (wr_busy_r)
        begin
            if (wr_end)
            begin
                wr_busy_r <= 1'b0;
                wr_tmr_r <= 32'h0;
                if (prot_r != PROT_PERM)
                begin
                    case (wr_op_r)
                        OP_REV: prot_r <= PROT_REV;
                        OP_CLR: prot_r <= PROT_NONE;
                        OP_PERM: prot_r <= PROT_PERM;
                        default: ;
                    endcase
                end
            end
            else
                wr_tmr_r <= wr_tmr_r - 32'h1;
        end
        else if (bus_stop && (pend_mem_r || pend_op_r != OP_NONE))
        begin
            wr_busy_r <= 1'b1;
            wr_tmr_r <= WR_CYC;
            wr_mem_r <= pend_mem_r;
            wr_op_r <= pend_op_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (wr_end && wr_mem_r)
        begin
            for (int i = 0; i < 16; i++)
            begin
                if (buf_v_r[i])
                    mem_a[{addr_cnt_r[7:4], 4'(i)}] <= buf_a[i];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            prot_o_r <= `SPDP_NV_NONE;
            sda_out_r <= 1'b0;
        end
        else
        begin
            case (prot_r)
                PROT_REV: prot_o_r <= `SPDP_NV_REV;
                PROT_PERM: prot_o_r <= `SPDP_NV_PERM;
                default: prot_o_r <= `SPDP_NV_NONE;
            endcase
        end
    end

    a_perm_sticky: assert property (prot_r == PROT_PERM |=> prot_r == PROT_PERM)
        else $error("permanent lock was lifted");
    a_rev_clear: assert property (wr_end && wr_op_r == OP_CLR && prot_r == PROT_REV |=> prot_r == PROT_NONE)
        else $error("clear did not remove reversible lock");

    c_seq_read: cover property (tx_load && state_r == ST_TX_ACK && tgt_r == TGT_MEM);
    c_perm_commit: cover property (wr_end && wr_op_r == OP_PERM);
    c_ts_write: cover property (data_done && tgt_r == TGT_TS && byte_idx_r == 2'h2);
    c_query_ack: cover property (state_r == ST_ADDR_ACK && tgt_r == TGT_PROT && rw_r && sda_oe_r);

    assign sda_oe = sda_oe_r;
    assign sda_out = sda_out_r;
    assign prot_state_o = prot_o_r;
    assign wr_busy_o = wr_busy_r;
endmodule // spdp_access

// ---- verif/spdp_host.sv ----
// Purpose: host controller model on the serial link
// Assumes: 12-cycle bit keeps low, high and setup times
// Notes: released SDA reads high through the pull-up
`timescale 1ns/1ps
module spdp_host
(
    input wire logic clk_sys,
    input wire logic sda_in,
    output logic scl_o,
    output logic sda_o
);
    // ****
    // bit and byte level
    // ****
    initial
    begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        tick(4);
        scl_o = 1'h1;
        tick(4);
        r = sda_in;
        scl_o = 1'h0;
        tick(4);
    endtask
    // clock stands high between frames
    task automatic start();
        sda_o = 1'h1;
        tick(4);
        scl_o = 1'h1;
        tick(4);
        sda_o = 1'h0;
        tick(4);
        scl_o = 1'h0;
        tick(4);
    endtask
    task automatic stop();
        sda_o = 1'h0;
        tick(4);
        scl_o = 1'h1;
        tick(4);
        sda_o = 1'h1;
        tick(8);
    endtask
    task automatic byte_w(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], r);
        bit_x(1'h1, r);
        ack = ~r;
    endtask
    task automatic byte_r(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'h1, d[i]);
        bit_x(~more, r);
    endtask
endmodule // spdp_host

// ---- verif/spdp_access_tb.sv ----
// Purpose: self-checking bench for spdp_access
// Assumes: host model drives the link; write cycle shortened
// Notes: integer model of store and lock; sensor words checked against the capability constant 16'h0017 and the values the bench drives
`timescale 1ns/1ps
module spdp_access_tb;
    // ****
    // harness and checks
    // ****
    localparam int WC = 300;
    logic clk_sys, rst_n, hs, sda, oe, hv, busy, ack, scl, so;
    logic [2:0] sel;
    logic [1:0] pst, npi;
    logic [15:0] tv, v;
    logic [7:0] d;
    int mismatches, comparisons, seed, cyc, prot_m, ctr_m;
    int mem_m [256];
    assign sda = hs & ~oe;
    spdp_host host (.clk_sys(clk_sys), .sda_in(sda), .scl_o(scl), .sda_o(hs));
    spdp_access #(.WR_CYC(WC)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(so), .sda_oe(oe), .addr_sel(sel), .hv_detect_in(hv), .nv_prot_init(npi),
        .temp_value_in(tv), .prot_state_o(pst), .wr_busy_o(busy));
    initial
    begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, input logic g);
        chk(w, {15'h0, e}, {15'h0, g});
    endtask
    // ****
    // transactions
    // ****
    task automatic send(input logic [7:0] sa, input logic [7:0] a, input int n, input logic [2:0] e, input logic wb);
        logic [7:0] p;
        p = a;
        host.start();
        host.byte_w(sa, ack);
        chk1("cmd ack", e[2], ack);
        host.byte_w(a, ack);
        chk1("addr ack", e[1], ack);
        repeat (n)
        begin
            v = $random(seed);
            host.byte_w(v[7:0], ack);
            chk1("data ack", e[0], ack);
            if (wb && sa[7:4] == 4'hA)
                mem_m[p] = int'(v[7:0]);
            p[3:0] = p[3:0] + 4'h1;
        end
        host.stop();
        chk1("write cycle", wb, busy);
        if (wb)
        begin
            host.start();
            host.byte_w(sa, ack);
            chk1("busy poll", 1'h0, ack);
            host.stop();
        end
        for (int i = 0; i < 400 && busy === 1'h1; i++)
            @(negedge clk_sys);
        chk1("write end", 1'h0, busy);
    endtask
    task automatic mem_wr(input logic [7:0] a, input int n);
        logic wb;
        wb = prot_m == 0 || a[7];
        send({4'hA, sel, 1'h0}, a, n, {2'h3, wb}, wb);
    endtask
    task automatic lock(input int op, input logic rd);
        logic ok, wb;
        hv = op != 2;
        ok = !(prot_m == 2 || (prot_m == 1 && op == 0));
        wb = ok && !rd && !(prot_m == 0 && op == 1);
        d = $random(seed);
        send({4'h6, (op == 2) ? sel : {1'h0, op == 1, 1'h0}, rd}, d, 1, rd ? {ok, 2'h0} : {3{ok}}, wb);
        if (wb)
            prot_m = (op == 0) ? 1 : (op == 1) ? 0 : 2;
        repeat (2) @(negedge clk_sys);
        chk("lock state", prot_m[15:0], {14'h0, pst});
    endtask
    task automatic rd_mem(input int a, input int n);
        if (a >= 0)
        begin
            host.start();
            host.byte_w({4'hA, sel, 1'h0}, ack);
            host.byte_w(a[7:0], ack);
            ctr_m = a;
        end
        host.start();
        host.byte_w({4'hA, sel, 1'h1}, ack);
        chk1("read ack", 1'h1, ack);
        for (int i = 0; i < n; i++)
        begin
            host.byte_r(i < n - 1, d);
            chk("read byte", mem_m[ctr_m][15:0], {8'h0, d});
            ctr_m = (ctr_m + 1) % 256;
        end
        host.stop();
    endtask
    task automatic ts(input int ptr, input logic wr, input logic [15:0] wv, input logic [15:0] exp);
        logic [15:0] got;
        if (ptr >= 0)
        begin
            host.start();
            host.byte_w({4'h3, sel, 1'h0}, ack);
            host.byte_w(ptr[7:0], ack);
            if (wr)
            begin
                host.byte_w(wv[15:8], ack);
                host.byte_w(wv[7:0], ack);
                chk1("sensor ack", 1'h1, ack);
            end
        end
        host.start();
        host.byte_w({4'h3, sel, 1'h1}, ack);
        host.byte_r(1'h1, got[15:8]);
        host.byte_r(1'h0, got[7:0]);
        host.stop();
        chk("sensor word", exp, got);
    endtask
    initial
    begin
        seed = 81079;
        rst_n = 1'h0;
        npi = 2'h0;
        hv = 1'h0;
        sel = 3'h5;
        tv = $random(seed);
        repeat (5) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (8) @(negedge clk_sys);
        ts(-1, 1'h0, 16'h0, 16'h0017);
        v = $random(seed);
        ts(8'h01, 1'h1, v, v);
        ts(8'h00, 1'h1, v, 16'h0017);
        ts(8'h05, 1'h0, v, tv);
        ts(-1, 1'h0, v, tv);
        mem_wr(8'h00, 8);
        mem_wr(8'hFE, 18);
        rd_mem(8'hFC, 8);
        rd_mem(-1, 2);
        lock(0, 1'h1);
        lock(1, 1'h0);
        lock(0, 1'h0);
        lock(0, 1'h0);
        lock(0, 1'h1);
        lock(1, 1'h1);
        lock(2, 1'h1);
        mem_wr(8'h02, 2);
        mem_wr(8'hF0, 2);
        lock(1, 1'h0);
        mem_wr(8'h06, 1);
        lock(0, 1'h0);
        lock(2, 1'h0);
        for (int op = 0; op < 6; op++)
            lock(op % 3, op / 3 == 1);
        mem_wr(8'h04, 2);
        rd_mem(8'h00, 8);
        rd_mem(8'hF0, 2);
        // mid-run reset: stored permanent lock must come back
        npi = 2'h2;
        rst_n = 1'h0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'h1;
        repeat (8) @(negedge clk_sys);
        chk("lock reload", 16'h0002, {14'h0, pst});
        chk1("data drive", 1'h0, so);
        lock(1, 1'h0);
        rd_mem(8'h00, 2);
        close_out();
    end
endmodule // spdp_access_tb
